// *** rtl/sscr_defines.svh ***
// Offsets, field positions, reset values and counts of the synth and security registers
`ifndef SSCR_DEFINES_SVH
`define SSCR_DEFINES_SVH
`define SSCR_ADDR_SYNTH 6'h18
`define SSCR_ADDR_SEC 6'h19
`define SSCR_THR_MSB 15
`define SSCR_THR_LSB 14
`define SSCR_CAL_DONE_BIT 13
`define SSCR_CAL_RUN_BIT 12
`define SSCR_LEN_BIT 11
`define SSCR_LOCK_BIT 10
`define SSCR_CHANNEL_FREQUENCY_WORD_MSB 9
`define SSCR_THR_RST 2'h1
`define SSCR_CHANNEL_FREQUENCY_WORD_RST 10'h165
`define SSCR_SEC_RST 10'h3c4
`define SSCR_SEC_WMASK 16'h03ff
`define SSCR_FC_BASE 12'h800
`define SSCR_RX_LO_OFFSET 12'h002
`define SSCR_MAC_LEN_OVERHEAD 8'h02
`define SSCR_WIN_SHORT 3'h2
`define SSCR_WIN_LONG 3'h4
`define SSCR_LOCK_BASE 10'h040
`endif

// *** rtl/sscr_pkg.sv ***
// Types of the synth and security configuration register block
`default_nettype none
package sscr_pkg;
  typedef enum logic [1:0] {
    SSCR_SEC_OFF = 2'h0,
    SSCR_SEC_CBC_MAC = 2'h1,
    SSCR_SEC_CTR = 2'h2,
    SSCR_SEC_CCM = 2'h3
  } sscr_mode_t;
  typedef struct packed {
    logic rx_buffer_guard_enable;
    logic mac_header_select;
    logic standalone_key_select;
    logic transmit_key_select;
    logic receive_key_select;
    logic [2:0] auth_field_size_code;
    sscr_mode_t inline_protection_mode;
  } sscr_sec_t;
  typedef struct packed {
    logic [11:0] carrier_mhz;
    logic [11:0] lo_mhz;
  } sscr_channel_frequency_word_t;
endpackage
`default_nettype wire

// *** rtl/sscr_regs.sv ***
// Synthesizer control/status and security control register block
//
// Behaviour
// - Lock declared after 64/128/256/512 consecutive good windows; threshold resets to 128.
// - Calibration-done flag at bit 13, set on calibration end, cleared at synth power-on.
// - Calibration-running flag at bit 12 shows calibration in progress, resets 0.
// - Window pulse width field: 0 gives 2 prescaler periods, 1 gives 4.
// - Lock indicator at bit 10, read-only, resets to 0.
// - Carrier MHz is 2048 plus 10-bit word; word resets to 357.
// - LO equals carrier on transmit, carrier minus 2 MHz on receive.
// - Header select picks first MAC byte in CBC-MAC mode only: data byte or authenticated length.
// - Transmit length is packet length minus tx cleartext minus 2; rx uses rx count.
// - Three key selects: standalone bit 7, transmit 6, receive 5; resets 1,1,0.
// - Auth field size code (M-2)/2, codes 1..7 give 4..16 bytes, reset 1.
// - Two-bit security mode resets 0: off, CBC-MAC, CTR, CCM.
// - Transmit and receive cleartext counts are 7-bit fields.
`default_nettype none
`include "sscr_defines.svh"
module sscr_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic synth_on,
  input wire logic cal_busy,
  input wire logic ref_tick,
  input wire logic window_ok,
  input wire logic tx_mode,
  input wire logic [6:0] transmit_cleartext_count,
  input wire logic [6:0] receive_cleartext_count,
  input wire logic [7:0] packet_length,
  output logic [2:0] window_periods,
  output sscr_pkg::sscr_sec_t sec_cfg,
  output sscr_pkg::sscr_channel_frequency_word_t channel_frequency_word_out,
  output logic [7:0] mac_first_len,
  output logic mac_len_first,
  output logic [4:0] auth_bytes,
  output logic tx_key,
  output logic rx_key,
  output logic sa_key,
  output logic lock_flag
);
  logic rst_s1;
  logic rst_sync_n;
  logic [2:0] syn_on_sync;
  logic [1:0] cal_sync;
  logic [1:0] tick_sync;
  logic [1:0] ok_sync;
  logic tick_q;
  logic cal_run;
  logic cal_run_q;
  logic cal_done;
  logic lock_q;
  logic [9:0] lock_cnt;
  logic [1:0] lock_count_threshold;
  logic lock_length_sel;
  logic [9:0] channel_frequency_word;
  logic [9:0] sec_q;
  // Decoding and derived values
  wire wr_synth = reg_wr && (reg_addr == `SSCR_ADDR_SYNTH);
  wire wr_sec = reg_wr && (reg_addr == `SSCR_ADDR_SEC);
  wire syn_on = syn_on_sync[1];
  wire syn_rise = syn_on_sync[1] & ~syn_on_sync[2];
  wire tick_edge = tick_sync[1] & ~tick_q;
  wire [9:0] lock_target = `SSCR_LOCK_BASE << lock_count_threshold;
  wire cal_fall = cal_run_q & ~cal_run;
  wire [11:0] carrier = `SSCR_FC_BASE + {2'h0, channel_frequency_word};
  wire [11:0] lo = tx_mode ? carrier : carrier - `SSCR_RX_LO_OFFSET;
  wire [7:0] tx_auth_len = packet_length - {1'b0, transmit_cleartext_count}
    - `SSCR_MAC_LEN_OVERHEAD;
  wire [7:0] rx_auth_len = {1'b0, receive_cleartext_count};
  wire [7:0] next_mac_len = tx_mode ? tx_auth_len : rx_auth_len;
  wire [15:0] synth_view = {lock_count_threshold, cal_done, cal_run, lock_length_sel,
    lock_q, channel_frequency_word};
  wire [15:0] sec_view = {6'h00, sec_q};
  wire [15:0] next_rdata = (reg_addr == `SSCR_ADDR_SYNTH) ? synth_view :
    (reg_addr == `SSCR_ADDR_SEC) ? sec_view : 16'h0000;
  wire sec_cbc = sec_q[1:0] == sscr_pkg::SSCR_SEC_CBC_MAC;
  wire hdr_on = sec_q[8] && sec_cbc;
  wire [4:0] next_auth = {1'b0, sec_q[4:2], 1'b0} + 5'h02;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_sync_n <= rst_s1;
    end
  end

  // Synchronisers for synthesizer power and calibration levels
  // Third power stage only feeds the rise detector, never the first flop
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      syn_on_sync <= 3'h0;
      cal_sync <= 2'h0;
    end else begin
      syn_on_sync <= {syn_on_sync[1:0], synth_on};
      cal_sync <= {cal_sync[0], cal_busy};
    end
  end

  // Synchronisers for reference tick and window outcome
  // Both share the same depth so the outcome lines up with its tick edge
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tick_sync <= 2'h0;
      ok_sync <= 2'h0;
      tick_q <= 1'b0;
    end else begin
      tick_sync <= {tick_sync[0], ref_tick};
      ok_sync <= {ok_sync[0], window_ok};
      tick_q <= tick_sync[1];
    end
  end

  // Calibration status flags
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cal_run <= 1'b0;
      cal_run_q <= 1'b0;
      cal_done <= 1'b0;
    end else begin
      cal_run <= cal_sync[1];
      cal_run_q <= cal_run;
      if (cal_fall) begin
        cal_done <= 1'b1;
      end else if (syn_rise) begin
        cal_done <= 1'b0;
      end
    end
  end

  // Lock detector: consecutive good windows per reference period
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      lock_cnt <= 10'h000;
      lock_q <= 1'b0;
    end else if (!syn_on) begin
      lock_cnt <= 10'h000;
      lock_q <= 1'b0;
    end else if (tick_edge) begin
      if (!ok_sync[1]) begin
        lock_cnt <= 10'h000;
        lock_q <= 1'b0;
      end else if (lock_cnt + 10'h001 >= lock_target) begin
        lock_cnt <= lock_target;
        lock_q <= 1'b1;
      end else begin
        lock_cnt <= lock_cnt + 10'h001;
      end
    end
  end

  // Writable synth fields; status bits ignore writes
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      lock_count_threshold <= `SSCR_THR_RST;
      lock_length_sel <= 1'b0;
      channel_frequency_word <= `SSCR_CHANNEL_FREQUENCY_WORD_RST;
    end else if (wr_synth) begin
      lock_count_threshold <= reg_wdata[`SSCR_THR_MSB:`SSCR_THR_LSB];
      lock_length_sel <= reg_wdata[`SSCR_LEN_BIT];
      channel_frequency_word <= reg_wdata[`SSCR_CHANNEL_FREQUENCY_WORD_MSB:0];
    end
  end

  // Writable security fields; reserved upper bits are never stored
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sec_q <= `SSCR_SEC_RST;
    end else if (wr_sec) begin
      sec_q <= reg_wdata[9:0];
    end
  end

  // Read data: loaded on a read strobe, holds until the next one
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // Window pulse width for the lock detector front end
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      window_periods <= `SSCR_WIN_SHORT;
    end else begin
      window_periods <= lock_length_sel ? `SSCR_WIN_LONG : `SSCR_WIN_SHORT;
    end
  end

  // Security configuration copy for the crypto engine
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sec_cfg <= '0;
    end else begin
      sec_cfg <= sscr_pkg::sscr_sec_t'(sec_q);
    end
  end

  // Carrier and oscillator pair; oscillator tracks the current direction
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      channel_frequency_word_out <= '0;
    end else begin
      channel_frequency_word_out <= {carrier, lo};
    end
  end

  // First MAC byte: length value and whether it leads the data
  // Length wraps modulo 256 when the tx cleartext count plus 2 exceeds the packet length
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mac_first_len <= 8'h00;
      mac_len_first <= 1'b0;
    end else begin
      mac_first_len <= next_mac_len;
      mac_len_first <= hdr_on;
    end
  end

  // Authentication field size; reserved code 0 still decodes to 2
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      auth_bytes <= 5'h00;
    end else begin
      auth_bytes <= next_auth;
    end
  end

  // Key selects per operation
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sa_key <= 1'b0;
      tx_key <= 1'b0;
      rx_key <= 1'b0;
    end else begin
      sa_key <= sec_q[7];
      tx_key <= sec_q[6];
      rx_key <= sec_q[5];
    end
  end

  // Lock status copy on a pin
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      lock_flag <= 1'b0;
    end else begin
      lock_flag <= lock_q;
    end
  end
endmodule
`default_nettype wire

// *** verification/sscr_regs_props.sv ***
// Port checker of the synth and security register block
`default_nettype none
module sscr_regs_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic synth_on,
  input wire logic tx_mode,
  input wire logic [2:0] window_periods,
  input wire sscr_pkg::sscr_sec_t sec_cfg,
  input wire sscr_pkg::sscr_channel_frequency_word_t channel_frequency_word_out,
  input wire logic mac_len_first,
  input wire logic [4:0] auth_bytes,
  input wire logic tx_key,
  input wire logic rx_key,
  input wire logic sa_key,
  input wire logic lock_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Oscillator offset by mode, held two edges
  a_lo_tx_equal: assert property ($past(tx_mode, 2) && $past(tx_mode) |->
    channel_frequency_word_out.lo_mhz == channel_frequency_word_out.carrier_mhz) else $error("lo wrong in tx");
  a_lo_rx_below: assert property (!$past(tx_mode, 2) && !$past(tx_mode)
    && channel_frequency_word_out.carrier_mhz != 12'h000 |-> channel_frequency_word_out.lo_mhz == channel_frequency_word_out.carrier_mhz - 12'h002)
    else $error("lo wrong in rx");
  // Security outputs follow a settled register
  a_key_selects: assert property ($stable(sec_cfg) ##1 $stable(sec_cfg) |->
    {sa_key, tx_key, rx_key} == sec_cfg[7:5]) else $error("key select wrong");
  a_auth_size: assert property ($stable(sec_cfg) ##1 ($stable(sec_cfg) && sec_cfg != '0) |->
    auth_bytes == {1'b0, sec_cfg[4:2], 1'b0} + 5'h02) else $error("auth size wrong");
  a_header_first: assert property ($stable(sec_cfg) ##1 $stable(sec_cfg) |->
    mac_len_first == (sec_cfg[8] && sec_cfg[1:0] == 2'h1)) else $error("header wrong");
  // Status seen in a synth register read; lock drops with synth off
  a_window_width: assert property ($past(reg_rd) && $past(reg_addr) == 6'h18 &&
    $stable(window_periods) |-> window_periods == (reg_rdata[11] ? 3'h4 : 3'h2))
    else $error("window width wrong");
  a_lock_bit_read: assert property ($past(reg_rd) && $past(reg_addr) == 6'h18 &&
    $stable(lock_flag) |-> reg_rdata[10] == lock_flag) else $error("lock bit wrong");
  a_lock_synth_off: assert property (lock_flag && !synth_on |-> ##[1:6] !lock_flag)
    else $error("lock kept with synth off");
endmodule
bind sscr_regs sscr_regs_props i_props (.*);
`default_nettype wire

// *** verification/sscr_host_model.sv ***
// Host model issuing register writes and reads
`default_nettype none
module sscr_host_model (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [5:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  end
  // One-cycle write; reserved bits cleared unless raw
  // Leading edge wait keeps back-to-back calls from retoggling a strobe in one step
  task automatic wr(input logic [5:0] a, input logic [15:0] d, input bit raw);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = (a == 6'h19 && !raw) ? (d & 16'h03ff) : d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  // One-cycle read; data taken after the sampling edge
  task automatic rd(input logic [5:0] a, output logic [15:0] q);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    q = reg_rdata;
  endtask
endmodule
`default_nettype wire

// *** verification/sscr_regs_tb.sv ***
// Testbench of the synth and security register block
`default_nettype none
module sscr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, reg_wr, reg_rd, synth_on, cal_busy, ref_tick, window_ok, tx_mode;
  logic [5:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, q;
  logic [6:0] transmit_cleartext_count, receive_cleartext_count;
  logic [7:0] packet_length, mac_first_len;
  logic [2:0] window_periods;
  logic [4:0] auth_bytes;
  logic mac_len_first, tx_key, rx_key, sa_key, lock_flag;
  sscr_pkg::sscr_sec_t sec_cfg;
  sscr_pkg::sscr_channel_frequency_word_t channel_frequency_word_out;
  int checked = 0;
  int bad_count = 0;
  // Word, mode, carrier, oscillator, window
  logic [43:0] rows [3] = '{{16'h0000, 1'b0, 12'h800, 12'h7fe, 3'h2},
    {16'hffff, 1'b1, 12'hbff, 12'hbff, 3'h4}, {16'h4165, 1'b0, 12'h965, 12'h963, 3'h2}};
  logic [15:0] secs [2] = '{16'hfd1d, 16'h02e2};
  sscr_regs i_dut (.*);
  sscr_host_model i_host (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      ref_tick = 1'b1;
      repeat (2) @(negedge clk);
      ref_tick = 1'b0;
      repeat (2) @(negedge clk);
    end
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog well beyond the roughly 650 cycles used
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    results();
  end
  initial begin
    {rst_n, synth_on, cal_busy, ref_tick, window_ok, tx_mode} = '0;
    {transmit_cleartext_count, receive_cleartext_count, packet_length} = '0;
    do_reset();
    foreach (rows[i]) begin
      tx_mode = rows[i][27];
      i_host.wr(6'h18, rows[i][43:28], 1'b0);
      repeat (3) @(negedge clk);
      i_host.rd(6'h18, q);
      chk("synth", rows[i][43:28] & 16'hcbff, q);
      chk("carrier", rows[i][26:15], channel_frequency_word_out.carrier_mhz);
      chk("lo", rows[i][14:3], channel_frequency_word_out.lo_mhz);
      chk("window", rows[i][2:0], window_periods);
    end
    foreach (secs[i]) begin
      i_host.wr(6'h19, secs[i], i == 0);
      repeat (3) @(negedge clk);
      i_host.rd(6'h19, q);
      chk("sec", secs[i] & 16'h03ff, q);
      chk("auth", {secs[i][4:2], 1'b0} + 5'h02, auth_bytes);
      chk("keys", secs[i][7:5], {sa_key, tx_key, rx_key});
      chk("header", secs[i][8] && secs[i][1:0] == 2'h1, mac_len_first);
    end
    i_host.rd(6'h1a, q);
    chk("unmapped", 16'h0000, q);
    $display("table done");
    packet_length = 8'h05;
    transmit_cleartext_count = 7'h04;
    tx_mode = 1'b1;
    repeat (3) @(negedge clk);
    chk("tx len", 8'hff, mac_first_len);
    tx_mode = 1'b0;
    receive_cleartext_count = 7'h7f;
    repeat (3) @(negedge clk);
    chk("rx len", 8'h7f, mac_first_len);
    $display("length done");
    synth_on = 1'b1;
    cal_busy = 1'b1;
    repeat (6) @(negedge clk);
    i_host.rd(6'h18, q);
    chk("cal run", 2'h1, q[13:12]);
    cal_busy = 1'b0;
    repeat (6) @(negedge clk);
    i_host.rd(6'h18, q);
    chk("cal done", 2'h2, q[13:12]);
    synth_on = 1'b0;
    repeat (6) @(negedge clk);
    synth_on = 1'b1;
    repeat (6) @(negedge clk);
    i_host.rd(6'h18, q);
    chk("cal clear", 2'h0, q[13:12]);
    $display("calibration done");
    i_host.wr(6'h18, 16'h0165, 1'b0);
    window_ok = 1'b1;
    tick(63);
    repeat (8) @(negedge clk);
    chk("lock early", 1'b0, lock_flag);
    tick(1);
    repeat (8) @(negedge clk);
    i_host.rd(6'h18, q);
    chk("lock", 2'h3, {lock_flag, q[10]});
    window_ok = 1'b0;
    tick(1);
    window_ok = 1'b1;
    repeat (8) @(negedge clk);
    chk("lock lost", 1'b0, lock_flag);
    tick(64);
    synth_on = 1'b0;
    repeat (8) @(negedge clk);
    chk("lock off", 1'b0, lock_flag);
    $display("lock done");
    do_reset();
    i_host.rd(6'h18, q);
    chk("synth reset", 16'h4165, q);
    i_host.rd(6'h19, q);
    chk("sec reset", 16'h03c4, q);
    $display("reset done");
    results();
  end
endmodule
`default_nettype wire
